// file: verilog/cal_seq_pkg.sv
// Constants and types for the background calibration sequencer
`default_nettype none
package cal_seq_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h90;
  localparam logic [7:0] IDX_STATUS = 8'h91;
  localparam logic [7:0] IDX_SLEEP = 8'h92;
  localparam logic [7:0] IDX_WAKE = 8'h93;
  localparam logic [7:0] IDX_SRC_DLY = 8'h9A;
  localparam logic [7:0] IDX_MUX_DLY = 8'h9B;
  localparam logic [7:0] IDX_TRIM0 = 8'hA0;
  localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_SLEEP = {2'b00, IDX_SLEEP, 2'b00};
  localparam logic [11:0] ADDR_WAKE = {2'b00, IDX_WAKE, 2'b00};
  localparam logic [11:0] ADDR_SRC_DLY = {2'b00, IDX_SRC_DLY, 2'b00};
  localparam logic [11:0] ADDR_MUX_DLY = {2'b00, IDX_MUX_DLY, 2'b00};
  localparam logic [11:0] ADDR_TRIM0 = {2'b00, IDX_TRIM0, 2'b00};
  localparam int NUM_CORES = 6;
  // Control register fields
  localparam int B_CAL_EN = 0;
  localparam int B_BG_EN = 1;
  localparam int B_TRIG_SRC = 2;
  localparam int B_SOFT_TRIG = 3;
  localparam int B_LOW_POWER_CAL_ENABLE = 4;
  localparam int B_LP_MANUAL = 5;
  localparam int B_STAT_SEL = 6;
  localparam int B_FG_OFS = 7;
  localparam int B_BG_OFS = 8;
  localparam int B_OFS_REF = 9;
  localparam int B_MODE = 10;
  localparam logic [1:0] MODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  // Values after reset
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [15:0] SLEEP_RESET = 16'h0100;
  localparam logic [15:0] WAKE_RESET = 16'h0010;
  localparam logic [7:0] SRC_DLY_RESET = 8'h00;
  localparam logic [7:0] MUX_DLY_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  // Glitch-reducing settings software is advised to load
  localparam logic [7:0] SRC_DLY_ADVISED = 8'h1F;
  localparam logic [7:0] MUX_DLY_ADVISED = 8'h1E;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FG_START, ST_FG_WAIT, ST_SLEEP, ST_WAKE,
    ST_CAL_START, ST_CAL_WAIT, ST_HOLD, ST_SWAP_SRC, ST_SWAP_MUX
  } seq_state_t;
endpackage
`default_nettype wire

// file: verilog/adc_background_calibration_sequencer.sv
// Background calibration sequencer with APB register slave
// Function
// - Quad: spare core 2 serves cores 0 and 1, spare 3 serves 4 and 5.
// - Dual: spare 2 shared by cores 0 and 1; single: spare 2 serves core 0.
// - Rotate cores endlessly; calibrated spare relieves next core, which is then calibrated.
// - At most one core is under calibration at any time.
// - Low-power mode keeps spares powered down until their calibration turn.
// - Low-power pacing bit: 0 automatic intervals, 1 manual by trigger.
// - Automatic: spare sleeps sleep time, then settles wake time before calibrating.
// - Automatic: swap at calibration end; relieved core becomes spare and sleeps.
// - Manual: spare stays asleep while trigger is high.
// - Manual: trigger low wakes spare; calibration starts after wake delay.
// - Manual: swap only after calibration done and trigger high again.
// - Status select 1 routes calibration-finished signal to status pin.
// - Foreground offset enable does one offset calibration in foreground pass.
// - Background offset enable keeps correcting offset in background calibrations.
// - Foreground offset set before calibration enable gives one-time offset only.
// - Offset results land in trim registers; software writes then blocked.
// - Foreground offset with background enabled calibrates all six cores in quad mode.
// - Spare reference option matches main core offsets to the spare.
`default_nettype none
module adc_background_calibration_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_trigger_pin,
  input wire logic cal_core_done,
  input wire logic trim_wr,
  input wire logic [2:0] trim_core,
  input wire logic [7:0] trim_value,
  output logic cal_start,
  output logic [2:0] cal_core,
  output logic cal_offset_en,
  output logic cal_offset_ref,
  output logic [5:0] core_power,
  output logic [11:0] channel_src,
  output logic cal_status_pin
);
  typedef struct packed {
    cal_seq_pkg::seq_state_t st;
    logic [11:0] ctrl;
    logic [15:0] sleep_dly;
    logic [15:0] wake_dly;
    logic [7:0] src_dly;
    logic [7:0] mux_dly;
    logic [5:0][7:0] trim;
    logic [31:0] prdata;
    logic [1:0] trig_sync;
    logic en_prev;
    logic [15:0] counter;
    logic [2:0] fg_idx;
    logic foreground_cal_done_flag;
    logic cal_finished_signal;
    logic grp;
    logic [1:0] next_slot;
    logic [1:0][2:0] spare;
    logic [3:0][2:0] src;
    logic cal_start;
    logic [2:0] cal_core;
    logic ofs_en;
    logic ofs_ref;
    logic [5:0] power;
    logic stat;
  } seq_t;

  seq_t q;
  seq_t n;
  logic access;
  logic mapped;
  logic trim_hit;
  logic [2:0] trim_sel;
  logic trig;
  logic [1:0] mode;
  logic lp;
  logic manual;
  logic bg;
  logic ofs_busy;
  logic [31:0] rd;

  function automatic logic slot_on(input logic [1:0] m, input int s);
    slot_on = (m == cal_seq_pkg::MODE_QUAD) ||
              (m == cal_seq_pkg::MODE_DUAL && s < 2) || (s == 0);
  endfunction

  function automatic logic grp_on(input logic [1:0] m, input int g);
    grp_on = (m == cal_seq_pkg::MODE_QUAD) || (g == 0);
  endfunction

  // Cores taken through the foreground pass
  function automatic logic core_used(input logic [1:0] m, input int i,
                                     input logic spares);
    case (i)
      0: core_used = 1'b1;
      1: core_used = (m != cal_seq_pkg::MODE_SINGLE);
      2: core_used = spares;
      3: core_used = spares && (m == cal_seq_pkg::MODE_QUAD);
      default: core_used = (m == cal_seq_pkg::MODE_QUAD);
    endcase
  endfunction

  assign mode = q.ctrl[cal_seq_pkg::B_MODE +: 2];
  assign lp = q.ctrl[cal_seq_pkg::B_LOW_POWER_CAL_ENABLE];
  assign manual = q.ctrl[cal_seq_pkg::B_LP_MANUAL];
  assign bg = q.ctrl[cal_seq_pkg::B_BG_EN];
  assign ofs_busy = q.ctrl[cal_seq_pkg::B_FG_OFS] || q.ctrl[cal_seq_pkg::B_BG_OFS];
  // Pin or software bit, as chosen by the trigger source select
  assign trig = q.ctrl[cal_seq_pkg::B_TRIG_SRC] ? q.trig_sync[1]
                                               : q.ctrl[cal_seq_pkg::B_SOFT_TRIG];
  assign access = psel && penable;
  assign trim_hit = (paddr >= cal_seq_pkg::ADDR_TRIM0) &&
                    (paddr <= cal_seq_pkg::ADDR_TRIM0 + 12'h014) && (paddr[1:0] == 2'b00);
  assign trim_sel = 3'(paddr[4:2] - cal_seq_pkg::ADDR_TRIM0[4:2]);

  always_comb begin
    mapped = 1'b1;
    rd = 32'h0000_0000;
    if (trim_hit) begin
      rd = {24'h000000, q.trim[trim_sel]};
    end else begin
      unique case (paddr)
        cal_seq_pkg::ADDR_CTRL: rd = {20'h00000, q.ctrl};
        cal_seq_pkg::ADDR_STATUS: rd = {24'h000000, q.st, q.cal_finished_signal, q.foreground_cal_done_flag, 2'b00};
        cal_seq_pkg::ADDR_SLEEP: rd = {16'h0000, q.sleep_dly};
        cal_seq_pkg::ADDR_WAKE: rd = {16'h0000, q.wake_dly};
        cal_seq_pkg::ADDR_SRC_DLY: rd = {24'h000000, q.src_dly};
        cal_seq_pkg::ADDR_MUX_DLY: rd = {24'h000000, q.mux_dly};
        default: mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    n = q;
    n.cal_start = 1'b0;
    n.trig_sync = {q.trig_sync[0], cal_trigger_pin};
    n.en_prev = q.ctrl[cal_seq_pkg::B_CAL_EN];
    if (psel && !penable) begin
      n.prdata = rd;
    end
    if (access && pwrite && mapped) begin
      unique case (paddr)
        cal_seq_pkg::ADDR_CTRL: n.ctrl = pwdata[11:0];
        cal_seq_pkg::ADDR_SLEEP: n.sleep_dly = pwdata[15:0];
        cal_seq_pkg::ADDR_WAKE: n.wake_dly = pwdata[15:0];
        cal_seq_pkg::ADDR_SRC_DLY: n.src_dly = pwdata[7:0];
        cal_seq_pkg::ADDR_MUX_DLY: n.mux_dly = pwdata[7:0];
        default: begin
          // Trims belong to the engine while offset calibration is in use
          if (trim_hit && !ofs_busy) begin
            n.trim[trim_sel] = pwdata[7:0];
          end
        end
      endcase
    end
    // Engine results win over a software write in the same cycle
    if (trim_wr && trim_core < 3'h6) begin
      n.trim[trim_core] = trim_value;
    end
    unique case (q.st)
      cal_seq_pkg::ST_IDLE: begin
        // Enable edge starts one foreground pass; offset enable is read as each core starts
        if (q.ctrl[cal_seq_pkg::B_CAL_EN] && !q.en_prev) begin
          n.fg_idx = 3'h0;
          n.foreground_cal_done_flag = 1'b0;
          n.st = cal_seq_pkg::ST_FG_START;
        end
      end
      cal_seq_pkg::ST_FG_START: begin
        if (q.fg_idx == 3'h6) begin
          n.foreground_cal_done_flag = 1'b1;
          if (bg) begin
            n.st = lp ? cal_seq_pkg::ST_SLEEP : cal_seq_pkg::ST_CAL_START;
            n.counter = q.sleep_dly;
          end else begin
            n.st = cal_seq_pkg::ST_IDLE;
          end
        end else if (core_used(mode, int'(q.fg_idx), bg)) begin
          n.cal_start = 1'b1;
          n.cal_core = q.fg_idx;
          n.ofs_en = q.ctrl[cal_seq_pkg::B_FG_OFS];
          n.ofs_ref = 1'b0;
          n.st = cal_seq_pkg::ST_FG_WAIT;
        end else begin
          n.fg_idx = 3'(q.fg_idx + 3'h1);
        end
      end
      cal_seq_pkg::ST_FG_WAIT: begin
        if (cal_core_done) begin
          n.fg_idx = 3'(q.fg_idx + 3'h1);
          n.st = cal_seq_pkg::ST_FG_START;
        end
      end
      cal_seq_pkg::ST_SLEEP: begin
        if (manual) begin
          if (!trig) begin
            n.counter = q.wake_dly;
            n.st = cal_seq_pkg::ST_WAKE;
          end
        end else if (q.counter == 16'h0000) begin
          n.counter = q.wake_dly;
          n.st = cal_seq_pkg::ST_WAKE;
        end else begin
          n.counter = 16'(q.counter - 16'h0001);
        end
      end
      cal_seq_pkg::ST_WAKE: begin
        if (q.counter == 16'h0000) begin
          n.st = cal_seq_pkg::ST_CAL_START;
        end else begin
          n.counter = 16'(q.counter - 16'h0001);
        end
      end
      cal_seq_pkg::ST_CAL_START: begin
        // Only the current group's spare is calibrated: one core at a time
        n.cal_start = 1'b1;
        n.cal_core = q.spare[q.grp];
        n.ofs_en = q.ctrl[cal_seq_pkg::B_BG_OFS];
        n.ofs_ref = q.ctrl[cal_seq_pkg::B_OFS_REF];
        n.cal_finished_signal = 1'b0;
        n.st = cal_seq_pkg::ST_CAL_WAIT;
      end
      cal_seq_pkg::ST_CAL_WAIT: begin
        if (cal_core_done) begin
          n.cal_finished_signal = 1'b1;
          n.counter = {8'h00, q.src_dly};
          n.st = (lp && manual) ? cal_seq_pkg::ST_HOLD
                                : cal_seq_pkg::ST_SWAP_SRC;
        end
      end
      cal_seq_pkg::ST_HOLD: begin
        // Spare stays powered until the trigger returns high
        if (trig) begin
          n.counter = {8'h00, q.src_dly};
          n.st = cal_seq_pkg::ST_SWAP_SRC;
        end
      end
      cal_seq_pkg::ST_SWAP_SRC: begin
        if (q.counter == 16'h0000) begin
          n.counter = {8'h00, q.mux_dly};
          n.st = cal_seq_pkg::ST_SWAP_MUX;
        end else begin
          n.counter = 16'(q.counter - 16'h0001);
        end
      end
      cal_seq_pkg::ST_SWAP_MUX: begin
        if (q.counter == 16'h0000) begin
          // Calibrated spare takes the slot; relieved core is the next spare
          if (mode == cal_seq_pkg::MODE_SINGLE) begin
            n.src[0] = q.spare[0];
            n.spare[0] = q.src[0];
          end else begin
            n.src[{q.grp, q.next_slot[q.grp]}] = q.spare[q.grp];
            n.spare[q.grp] = q.src[{q.grp, q.next_slot[q.grp]}];
            n.next_slot[q.grp] = ~q.next_slot[q.grp];
          end
          n.grp = ~q.grp;
          n.counter = q.sleep_dly;
          n.st = lp ? cal_seq_pkg::ST_SLEEP
                    : cal_seq_pkg::ST_CAL_START;
        end else begin
          n.counter = 16'(q.counter - 16'h0001);
        end
      end
    endcase

    if (!q.ctrl[cal_seq_pkg::B_CAL_EN] || (!bg && q.st > cal_seq_pkg::ST_FG_WAIT)) begin
      n.st = cal_seq_pkg::ST_IDLE;
    end
    if (mode == cal_seq_pkg::MODE_DUAL || mode == cal_seq_pkg::MODE_SINGLE) begin
      n.grp = 1'b0;
    end

    // Spares sleep in low-power mode except during their own turn
    for (int i = 0; i < cal_seq_pkg::NUM_CORES; i++) begin
      n.power[i] = 1'b0;
      for (int s = 0; s < 4; s++) begin
        if (slot_on(mode, s) && q.src[s] == 3'(i)) begin
          n.power[i] = 1'b1;
        end
      end
      for (int g = 0; g < 2; g++) begin
        if (grp_on(mode, g) && q.spare[g] == 3'(i) && bg &&
            q.st > cal_seq_pkg::ST_FG_WAIT &&
            (!lp || (q.grp == 1'(g) && q.st >= cal_seq_pkg::ST_WAKE))) begin
          n.power[i] = 1'b1;
        end
      end
      if ((q.st == cal_seq_pkg::ST_FG_START || q.st == cal_seq_pkg::ST_FG_WAIT) &&
          core_used(mode, i, bg)) begin
        n.power[i] = 1'b1;
      end
    end
    n.stat = q.ctrl[cal_seq_pkg::B_STAT_SEL] ? n.cal_finished_signal
                                            : (n.st != cal_seq_pkg::ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= cal_seq_pkg::ST_IDLE;
      q.ctrl <= cal_seq_pkg::CTRL_RESET;
      q.sleep_dly <= cal_seq_pkg::SLEEP_RESET;
      q.wake_dly <= cal_seq_pkg::WAKE_RESET;
      q.src_dly <= cal_seq_pkg::SRC_DLY_RESET;
      q.mux_dly <= cal_seq_pkg::MUX_DLY_RESET;
      q.trim <= {6{cal_seq_pkg::TRIM_RESET}};
      q.spare <= {3'h3, 3'h2};
      q.src <= {3'h5, 3'h4, 3'h1, 3'h0};
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign cal_start = q.cal_start;
  assign cal_core = q.cal_core;
  assign cal_offset_en = q.ofs_en;
  assign cal_offset_ref = q.ofs_ref;
  assign core_power = q.power;
  assign channel_src = q.src;
  assign cal_status_pin = q.stat;

  property p_one_core;
    @(posedge pclk) disable iff (!presetn)
    (q.st == cal_seq_pkg::ST_CAL_WAIT || q.st == cal_seq_pkg::ST_FG_WAIT) && !cal_core_done
      |=> !q.cal_start;
  endproperty
  a_one_core: assert property (p_one_core) else $error("second core started");

  property p_quad_group;
    @(posedge pclk) disable iff (!presetn)
    q.cal_start && q.st == cal_seq_pkg::ST_CAL_WAIT && q.grp == 1'b1
      |-> (q.cal_core == 3'h3 || q.cal_core == 3'h4 || q.cal_core == 3'h5);
  endproperty
  a_quad_group: assert property (p_quad_group) else $error("core outside group");

  property p_lp_sleep;
    @(posedge pclk) disable iff (!presetn)
    lp && $past(lp) && q.st == cal_seq_pkg::ST_SLEEP && $past(q.st) == cal_seq_pkg::ST_SLEEP
      |-> !q.power[q.spare[q.grp]];
  endproperty
  a_lp_sleep: assert property (p_lp_sleep) else $error("sleeping spare powered");

  property p_wake_load;
    @(posedge pclk) disable iff (!presetn)
    q.st == cal_seq_pkg::ST_SLEEP ##1 q.st == cal_seq_pkg::ST_WAKE
      |-> q.counter == $past(q.wake_dly);
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("wake delay not loaded");

  property p_manual_sleep;
    @(posedge pclk) disable iff (!presetn)
    q.st == cal_seq_pkg::ST_SLEEP && manual && trig && q.ctrl[cal_seq_pkg::B_CAL_EN] && bg
      && !(access && pwrite) |=> q.st == cal_seq_pkg::ST_SLEEP;
  endproperty
  a_manual_sleep: assert property (p_manual_sleep) else $error("woke on high trigger");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    q.st == cal_seq_pkg::ST_HOLD && !trig && q.ctrl[cal_seq_pkg::B_CAL_EN] && bg
      && !(access && pwrite) |=> q.st == cal_seq_pkg::ST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("swap before trigger high");

  property p_auto_swap;
    @(posedge pclk) disable iff (!presetn)
    q.st == cal_seq_pkg::ST_CAL_WAIT && cal_core_done && !(lp && manual) && !(access && pwrite)
      && q.ctrl[cal_seq_pkg::B_CAL_EN] && bg |=> q.st == cal_seq_pkg::ST_SWAP_SRC;
  endproperty
  a_auto_swap: assert property (p_auto_swap) else $error("no swap after calibration");
  property p_status;
    @(posedge pclk) disable iff (!presetn)
    q.st == cal_seq_pkg::ST_CAL_WAIT && cal_core_done && q.ctrl[cal_seq_pkg::B_STAT_SEL]
      && !(access && pwrite) |=> cal_status_pin;
  endproperty
  a_status: assert property (p_status) else $error("finished not on status pin");
  property p_trim_lock;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && trim_hit && ofs_busy && !trim_wr |=> q.trim == $past(q.trim);
  endproperty
  a_trim_lock: assert property (p_trim_lock) else $error("trim written during offset cal");
endmodule // adc_background_calibration_sequencer
`default_nettype wire

// file: testbench/adc_background_calibration_sequencer_tb.sv
// Self-checking bench for the background calibration sequencer
`default_nettype none
module adc_background_calibration_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_t;
  localparam logic [11:0] a_ct = cal_seq_pkg::ADDR_CTRL;
  localparam logic [11:0] a_wk = cal_seq_pkg::ADDR_WAKE;
  localparam logic [11:0] a_sd = cal_seq_pkg::ADDR_SRC_DLY;
  localparam logic [11:0] a_md = cal_seq_pkg::ADDR_MUX_DLY;
  localparam logic [11:0] a_t3 = cal_seq_pkg::ADDR_TRIM0 + 12'h00C;
  localparam logic [31:0] k_ce = 32'h1 << cal_seq_pkg::B_CAL_EN;
  localparam logic [31:0] k_bg = 32'h1 << cal_seq_pkg::B_BG_EN;
  localparam logic [31:0] k_st = 32'h1 << cal_seq_pkg::B_SOFT_TRIG;
  localparam logic [31:0] k_lp = 32'h1 << cal_seq_pkg::B_LOW_POWER_CAL_ENABLE;
  localparam logic [31:0] k_lm = 32'h1 << cal_seq_pkg::B_LP_MANUAL;
  localparam logic [31:0] k_ss = 32'h1 << cal_seq_pkg::B_STAT_SEL;
  localparam logic [31:0] k_fo = 32'h1 << cal_seq_pkg::B_FG_OFS;
  localparam logic [31:0] k_bo = 32'h1 << cal_seq_pkg::B_BG_OFS;
  localparam logic [31:0] k_ts = 32'h1 << cal_seq_pkg::B_TRIG_SRC;
  localparam logic [31:0] k_or = 32'h1 << cal_seq_pkg::B_OFS_REF;
  // Channel slots {5,4,1,0}, three bits each
  localparam logic [11:0] src_rst = 12'hB08;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cal_start, cal_status_pin, cal_offset_en, cal_offset_ref;
  logic cal_core_done = 1'b0, trim_wr = 1'b0, trig_pin = 1'b1;
  logic [2:0] trim_core = 3'h0;
  logic [7:0] trim_value = 8'h00;
  logic [2:0] cal_core;
  logic [5:0] core_power;
  logic [11:0] channel_src, prev;
  int fail_count = 0, cmp_count = 0, cyc = 0, eng_cnt = 0, i, n, t0;
  logic [2:0] started[$];
  int start_cyc[$];
  logic [31:0] rd;
  logic er;
  row_t rows [14] = '{
    '{1'b0, a_ct, 32'h0, 32'h0, 1'b0},
    '{1'b0, cal_seq_pkg::ADDR_SLEEP, 32'h0, 32'h100, 1'b0},
    '{1'b0, a_wk, 32'h0, 32'h10, 1'b0},
    '{1'b0, a_sd, 32'h0, 32'h0, 1'b0},
    '{1'b0, a_md, 32'h0, 32'h0, 1'b0},
    '{1'b0, a_t3, 32'h0, 32'h0, 1'b0},
    '{1'b1, a_sd, 32'hFFFFFF1F, 32'h0, 1'b0},
    '{1'b0, a_sd, 32'h0, 32'h1F, 1'b0},
    '{1'b1, a_md, 32'h1E, 32'h0, 1'b0},
    '{1'b0, a_md, 32'h0, 32'h1E, 1'b0},
    '{1'b1, 12'h000, 32'h5, 32'h0, 1'b1},
    '{1'b0, 12'h000, 32'h0, 32'h0, 1'b1},
    '{1'b1, a_wk, 32'h3, 32'h0, 1'b0},
    '{1'b0, a_wk, 32'h0, 32'h3, 1'b0}
  };
  logic [2:0] qexp [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2, 3'h3, 3'h0};
  logic [11:0] qsrc [3] = '{12'hB0A, 12'hACA, 12'hAC2};
  logic [2:0] dexp [2][5] = '{'{3'h0, 3'h1, 3'h2, 3'h2, 3'h0}, '{3'h0, 3'h2, 3'h2, 3'h0, 3'h0}};
  int dn [2] = '{5, 4};
  logic [1:0] dmode [2] = '{cal_seq_pkg::MODE_DUAL, cal_seq_pkg::MODE_SINGLE};

  adc_background_calibration_sequencer adc_background_calibration_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_trigger_pin(trig_pin), .cal_core_done(cal_core_done), .trim_wr(trim_wr),
    .trim_core(trim_core), .trim_value(trim_value), .cal_start(cal_start),
    .cal_core(cal_core), .cal_offset_en(cal_offset_en), .cal_offset_ref(cal_offset_ref),
    .core_power(core_power), .channel_src(channel_src), .cal_status_pin(cal_status_pin)
  );

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Calibration engine stand-in: finishes each core four cycles after its start
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    cal_core_done <= 1'b0;
    if (eng_cnt == 1) cal_core_done <= 1'b1;
    if (eng_cnt != 0) eng_cnt <= eng_cnt - 1;
    if (cal_start === 1'b1) begin
      chk(32'(eng_cnt), 32'h0, "start overlap");
      started.push_back(cal_core);
      start_cyc.push_back(cyc);
      eng_cnt <= 4;
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge pclk);
    chk(32'(pready), 32'h1, "pready");
    chk(32'(channel_src), 32'(src_rst), "reset slots");
    chk(32'(core_power), 32'h0, "reset power");
    @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].a, rows[k].d);
      if (!rows[k].wr) chk(rd, rows[k].e, "read");
      chk(32'(er), 32'(rows[k].er), "slverr");
    end
    // Engine trim result, then software writes guarded by offset calibration
    @(posedge pclk);
    trim_wr <= 1'b1;
    trim_core <= 3'h3;
    trim_value <= 8'h5A;
    @(posedge pclk);
    trim_wr <= 1'b0;
    rdchk(a_t3, 32'h5A, "engine trim");
    wr(a_ct, k_bo);
    wr(a_t3, 32'h11);
    rdchk(a_t3, 32'h5A, "trim guarded");
    wr(a_ct, 32'h0);
    wr(a_t3, 32'h11);
    rdchk(a_t3, 32'h11, "trim open");
    // Quad background rotation with advised swap delays
    started.delete();
    start_cyc.delete();
    prev = src_rst;
    wr(a_ct, k_ce | k_bg | k_st | k_ss | k_fo);
    for (i = 0; i < 200 && started.size() < 1; i++) @(posedge pclk);
    chk(32'(cal_offset_en), 32'h1, "fg offset");
    for (n = 0; n < 3; n++) begin
      for (i = 0; i < 2000 && started.size() < 7 + n; i++) @(posedge pclk);
      for (i = 0; i < 50 && cal_core_done !== 1'b1; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk(32'(cal_status_pin), 32'h1, "stopped");
      chk(32'(channel_src), 32'(prev), "early swap");
      for (i = 0; i < 400 && channel_src === prev; i++) @(posedge pclk);
      chk(32'(channel_src), 32'(qsrc[n]), "swap");
      prev = qsrc[n];
    end
    for (i = 0; i < 9; i++) chk(32'(started[i]), 32'(qexp[i]), "quad order");
    chk(32'(cal_offset_en), 32'h0, "offset one-shot");
    apb(1'b0, cal_seq_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h1, "foreground_cal_done_flag before trims");
    wr(a_ct, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(cal_status_pin), 32'h0, "abort idle");
    // Dual and single variants from a fresh reset
    for (n = 0; n < 2; n++) begin
      do_reset();
      started.delete();
      wr(a_ct, k_ce | k_bg | k_st | (32'(dmode[n]) << cal_seq_pkg::B_MODE));
      for (i = 0; i < 3000 && started.size() < dn[n]; i++) @(posedge pclk);
      wr(a_ct, 32'h0);
      for (i = 0; i < dn[n]; i++) chk(32'(started[i]), 32'(dexp[n][i]), "order");
    end
    // Low-power manual pacing by the software trigger, then automatic
    do_reset();
    chk(32'(channel_src), 32'(src_rst), "slots after reset");
    wr(a_wk, 32'h3);
    started.delete();
    start_cyc.delete();
    wr(a_ct, k_ce | k_bg | k_st | k_lp | k_lm | k_ss);
    for (i = 0; i < 2000 && started.size() < 6; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk(32'(started.size()), 32'h6, "asleep");
    chk(32'(core_power[2]), 32'h0, "spare off");
    t0 = cyc;
    wr(a_ct, k_ce | k_bg | k_lp | k_lm | k_ss);
    for (i = 0; i < 200 && started.size() < 7; i++) @(posedge pclk);
    chk(32'(started[6]), 32'h2, "woken spare");
    chk(32'(start_cyc[6] - t0 > 6), 32'h1, "wake settle");
    chk(32'(core_power[2]), 32'h1, "spare on");
    repeat (20) @(posedge pclk);
    chk(32'(channel_src), 32'(src_rst), "held low");
    chk(32'(cal_status_pin), 32'h1, "done shown");
    wr(a_ct, k_ce | k_bg | k_st | k_lp | k_lm | k_ss);
    for (i = 0; i < 200 && channel_src === src_rst; i++) @(posedge pclk);
    chk(32'(channel_src), 32'hB0A, "manual swap");
    repeat (4) @(posedge pclk);
    chk(32'(core_power[0]), 32'h0, "relieved off");
    t0 = cyc;
    wr(a_ct, k_ce | k_bg | k_st | k_lp | k_ss | k_bo | k_or);
    for (i = 0; i < 1000 && started.size() < 8; i++) @(posedge pclk);
    chk(32'(started[7]), 32'h3, "auto pace");
    chk(32'(start_cyc[7] - t0 > 200), 32'h1, "sleep span");
    chk(32'(cal_offset_en), 32'h1, "bg offset");
    chk(32'(cal_offset_ref), 32'h1, "spare reference");
    for (i = 0; i < 200 && channel_src === 12'hB0A; i++) @(posedge pclk);
    chk(32'(channel_src), 32'hACA, "auto swap");
    // Manual pacing from the trigger pin, through its synchroniser
    wr(a_ct, k_ce | k_bg | k_ts | k_lp | k_lm | k_ss);
    repeat (20) @(posedge pclk);
    chk(32'(started.size()), 32'h8, "pin high asleep");
    trig_pin <= 1'b0;
    for (i = 0; i < 200 && started.size() < 9; i++) @(posedge pclk);
    chk(32'(started[8]), 32'h0, "pin wake");
    results();
  end
endmodule // adc_background_calibration_sequencer_tb
`default_nettype wire
